// File: hw/qdc_pkg.sv
// Shared constants, command word layout and channel state types for the quad converter command decoder.
package qdc_pkg;

  localparam int            WORD_BITS     = 24;
  localparam int            NUM_CH        = 4;
  localparam int            CODE_BITS     = 14;
  localparam logic [4:0]    LAST_BIT_IDX  = 5'h17;

  // Positions inside the 14-bit payload field (word bits 15 down to 2).
  localparam int            MODE_HI_IDX   = 13;
  localparam int            MODE_LO_IDX   = 12;
  localparam int            REF_HI_IDX    = 11;
  localparam int            REF_LO_IDX    = 10;

  localparam logic [1:0]    PD_NORMAL     = 2'h0;
  localparam logic [1:0]    PD_1K         = 2'h1;
  localparam logic [1:0]    PD_100K       = 2'h2;
  localparam logic [1:0]    PD_HIZ        = 2'h3;

  localparam logic [1:0]    LD_BUFFER     = 2'h0;
  localparam logic [1:0]    LD_SINGLE     = 2'h1;
  localparam logic [1:0]    LD_ALL        = 2'h2;
  localparam logic [1:0]    LD_BROADCAST  = 2'h3;

  localparam logic [1:0]    SEL_BROADCAST = 2'h2;
  localparam logic [1:0]    SEL_REF       = 2'h0;

  localparam logic [1:0]    REF_CTL_AUTO  = 2'h0;
  localparam logic [1:0]    REF_CTL_ON    = 2'h1;
  localparam logic [1:0]    REF_CTL_OFF   = 2'h2;

  localparam logic [13:0]   CODE_RESET    = 14'h0000;
  localparam logic [1:0]    MODE_RESET    = 2'h0;
  localparam logic [23:0]   WORD_RESET    = 24'h000000;

  typedef enum logic [1:0] {
    REF_AUTO,
    REF_FORCED_ON,
    REF_FORCED_OFF
  } qdc_ref_e;

  typedef struct packed {
    logic [1:0]  reservedHi;
    logic        updateAllBit;
    logic        singleLoadBit;
    logic        reservedMid;
    logic [1:0]  chanSel;
    logic        powerDownEnableBit;
    logic [13:0] code;
    logic [1:0]  dontCare;
  } qdc_word_s;

  typedef struct packed {
    logic [1:0]  pdMode;
    logic [13:0] code;
  } qdc_chan_s;

endpackage : qdc_pkg

// File: hw/qdc_serial_rx.sv
// Serial-clock domain shift register that collects 24-bit command frames.
`timescale 1ns/1ns
module qdc_serial_rx
  import qdc_pkg::*;
(
  input  wire logic        sclk,
  input  wire logic        resetn,
  input  wire logic        frameSelN,
  input  wire logic        serialData,
  output qdc_pkg::qdc_word_s rxWord,
  output logic             rxToggle
);

  logic        rstSync1_reg;
  logic        rstSync2_reg;
  logic [4:0]  bitCount_reg;
  logic [4:0]  bitCount_next;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [23:0] word_reg;
  logic [23:0] word_next;
  logic        toggle_reg;
  logic        toggle_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release is brought into the serial-clock domain.
  always_ff @(negedge sclk) begin
    rstSync1_reg <= resetn;
    rstSync2_reg <= rstSync1_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bits are taken on falling edges; a frame ends with its 24th bit and later bits are dropped.
  always_comb begin
    bitCount_next = bitCount_reg;
    shift_next    = shift_reg;
    word_next     = word_reg;
    toggle_next   = toggle_reg;
    if (frameSelN) begin
      bitCount_next = 5'h00; // [R18]
    end else if (bitCount_reg <= LAST_BIT_IDX) begin
      shift_next    = {shift_reg[22:0], serialData};
      bitCount_next = bitCount_reg + 5'h01;
      if (bitCount_reg == LAST_BIT_IDX) begin
        word_next   = {shift_reg[22:0], serialData}; // [R01]
        toggle_next = ~toggle_reg;
      end
    end
  end

  always_ff @(negedge sclk) begin
    if (!rstSync2_reg) begin
      bitCount_reg <= 5'h00;
      shift_reg    <= WORD_RESET;
      word_reg     <= WORD_RESET;
      toggle_reg   <= 1'b0;
    end else begin
      bitCount_reg <= bitCount_next;
      shift_reg    <= shift_next;
      word_reg     <= word_next;
      toggle_reg   <= toggle_next;
    end
  end

  assign rxWord   = qdc_word_s'(word_reg);
  assign rxToggle = toggle_reg;

endmodule : qdc_serial_rx

// File: hw/qdc_command_decoder.sv
// Command decoder for a four-channel converter: buffers, active registers and reference control.
//
// What this block does and what it expects of the host
// [R01] Act only after the 24th serial bit.
// [R02] Bits 18:17 select channel A to D.
// [R03] Load bits 00 write only the buffer.
// [R04] Single load writes buffer, updates that channel.
// [R05] Update-all writes buffer, transfers all four.
// [R06] Broadcast select 10 powers down all channels.
// [R07] Broadcast with normal word updates all channels.
// [R08] Mode bits choose 1k, 100k or high-Z.
// [R09] Reference command 01 forces reference on.
// [R10] Reference command 10 forces reference off.
// [R11] Reference command 00 restores automatic mode.
// [R12] Reset leaves reference in automatic mode.
// [R13] Automatic reference powers down when all down.
// [R14] Automatic reference wakes on a normal load.
// [R15] Forced-on reference stays up when all down.
// [R16] Normal word leaves power-down with new code.
// [R17] Stored codes survive power-down.
// [R18] Host toggles frame select only around clocks.
// [R19] Code bits 15:2, MSB first, others zero.
`timescale 1ns/1ns
module qdc_command_decoder
  import qdc_pkg::*;
#(
  parameter int NUM_CHAN = NUM_CH
)
(
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  input  wire logic                            sclk,
  input  wire logic                            frameSelN,
  input  wire logic                            serialData,
  output qdc_pkg::qdc_chan_s [NUM_CHAN-1:0]    activeChan,
  output qdc_pkg::qdc_chan_s [NUM_CHAN-1:0]    bufferChan,
  output qdc_pkg::qdc_ref_e                    refMode,
  output logic                                 refPowered,
  output qdc_pkg::qdc_word_s                   cmdWord,
  output logic                                 cmdStrobe,
  output logic                                 cmdIgnored
);

  qdc_word_s                 rxWord;
  logic                      rxToggle;
  logic                      tglSync1_reg;
  logic                      tglSync2_reg;
  logic                      tglSeen_reg;
  logic                      newWord;

  qdc_chan_s [NUM_CHAN-1:0]  buf_reg;
  qdc_chan_s [NUM_CHAN-1:0]  buf_next;
  qdc_chan_s [NUM_CHAN-1:0]  act_reg;
  qdc_chan_s [NUM_CHAN-1:0]  act_next;
  qdc_chan_s [NUM_CHAN-1:0]  entry;
  logic      [NUM_CHAN-1:0]  writeMask;
  logic      [NUM_CHAN-1:0]  loadMask;
  logic      [NUM_CHAN-1:0]  chanDown;
  qdc_ref_e                  refMode_reg;
  qdc_ref_e                  refMode_next;
  logic                      refPowered_reg;
  logic                      refPowered_next;
  qdc_word_s                 cmdWord_reg;
  qdc_word_s                 cmdWord_next;
  logic                      cmdStrobe_reg;
  logic                      cmdStrobe_next;
  logic                      cmdIgnored_reg;
  logic                      cmdIgnored_next;

  logic [1:0]                loadCtl;
  logic [1:0]                pdMode;
  logic [1:0]                refCtl;
  logic                      refCmd;
  logic                      entryValid;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial receiver in the serial-clock domain.
  qdc_serial_rx u_rx (
    .sclk       (sclk),
    .resetn     (resetn),
    .frameSelN  (frameSelN),
    .serialData (serialData),
    .rxWord     (rxWord),
    .rxToggle   (rxToggle)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // The frame toggle crosses on two flops; the word is held stable far longer than the crossing takes.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tglSync1_reg <= 1'b0;
      tglSync2_reg <= 1'b0;
      tglSeen_reg  <= 1'b0;
    end else begin
      tglSync1_reg <= rxToggle;
      tglSync2_reg <= tglSync1_reg;
      tglSeen_reg  <= tglSync2_reg;
    end
  end

  assign newWord = tglSync2_reg ^ tglSeen_reg; // [R01]

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode of the received word.
  assign loadCtl = {rxWord.updateAllBit, rxWord.singleLoadBit};
  assign pdMode  = {rxWord.code[MODE_HI_IDX], rxWord.code[MODE_LO_IDX]}; // [R08]
  assign refCtl  = {rxWord.code[REF_HI_IDX], rxWord.code[REF_LO_IDX]};
  assign refCmd  = rxWord.powerDownEnableBit && (loadCtl == LD_BUFFER) &&
                   (rxWord.chanSel == SEL_REF) && (pdMode == PD_NORMAL); // [R09]

  // A power-down word with mode 00 outside the reference prefix, and load 11 with any select but 10, are ignored.
  assign entryValid = !(rxWord.powerDownEnableBit && (pdMode == PD_NORMAL)) &&
                      !((loadCtl == LD_BROADCAST) && (rxWord.chanSel != SEL_BROADCAST));

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel buffer entry, write mask and load mask.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      always_comb begin
        if (rxWord.powerDownEnableBit) begin
          entry[gi].pdMode = pdMode; // [R08]
          entry[gi].code   = buf_reg[gi].code; // [R17]
        end else begin
          entry[gi].pdMode = PD_NORMAL; // [R16]
          entry[gi].code   = rxWord.code; // [R19]
        end
      end

      always_comb begin
        if (loadCtl == LD_BROADCAST) begin
          writeMask[gi] = 1'b1; // [R06] [R07]
        end else begin
          writeMask[gi] = (rxWord.chanSel == 2'(gi)); // [R02]
        end
      end

      always_comb begin
        case (loadCtl)
          LD_BUFFER: begin
            loadMask[gi] = 1'b0; // [R03]
          end
          LD_SINGLE: begin
            loadMask[gi] = (rxWord.chanSel == 2'(gi)); // [R04]
          end
          LD_ALL: begin
            loadMask[gi] = 1'b1; // [R05]
          end
          default: begin
            loadMask[gi] = 1'b1; // [R06] [R07]
          end
        endcase
      end

      assign chanDown[gi] = (act_next[gi].pdMode != PD_NORMAL);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Command execution: buffers, active registers and reference mode.
  always_comb begin
    buf_next        = buf_reg;
    act_next        = act_reg;
    refMode_next    = refMode_reg;
    cmdWord_next    = cmdWord_reg;
    cmdStrobe_next  = 1'b0;
    cmdIgnored_next = 1'b0;
    if (newWord) begin
      cmdWord_next   = rxWord;
      cmdStrobe_next = 1'b1;
      if (refCmd) begin
        case (refCtl)
          REF_CTL_AUTO: begin
            refMode_next = REF_AUTO; // [R11]
          end
          REF_CTL_ON: begin
            refMode_next = REF_FORCED_ON; // [R09]
          end
          REF_CTL_OFF: begin
            refMode_next = REF_FORCED_OFF; // [R10]
          end
          default: begin
            cmdIgnored_next = 1'b1;
          end
        endcase
      end else if (!entryValid) begin
        cmdIgnored_next = 1'b1;
      end else begin
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (writeMask[i]) begin
            buf_next[i] = entry[i]; // [R03]
          end
        end
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (loadMask[i]) begin
            act_next[i] = buf_next[i]; // [R04] [R05]
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference power follows the mode, and in automatic mode the channel states.
  always_comb begin
    case (refMode_next)
      REF_FORCED_ON: begin
        refPowered_next = 1'b1; // [R15]
      end
      REF_FORCED_OFF: begin
        refPowered_next = 1'b0; // [R10]
      end
      default: begin
        refPowered_next = ~(&chanDown); // [R13] [R14]
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        buf_reg[i].pdMode <= MODE_RESET;
        buf_reg[i].code   <= CODE_RESET;
        act_reg[i].pdMode <= MODE_RESET;
        act_reg[i].code   <= CODE_RESET;
      end
      refMode_reg    <= REF_AUTO; // [R12]
      refPowered_reg <= 1'b1; // [R12]
      cmdWord_reg    <= qdc_word_s'(WORD_RESET);
      cmdStrobe_reg  <= 1'b0;
      cmdIgnored_reg <= 1'b0;
    end else begin
      buf_reg        <= buf_next;
      act_reg        <= act_next;
      refMode_reg    <= refMode_next;
      refPowered_reg <= refPowered_next;
      cmdWord_reg    <= cmdWord_next;
      cmdStrobe_reg  <= cmdStrobe_next;
      cmdIgnored_reg <= cmdIgnored_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from registers.
  assign activeChan = act_reg;
  assign bufferChan = buf_reg;
  assign refMode    = refMode_reg;
  assign refPowered = refPowered_reg;
  assign cmdWord    = cmdWord_reg;
  assign cmdStrobe  = cmdStrobe_reg;
  assign cmdIgnored = cmdIgnored_reg;

endmodule : qdc_command_decoder

// File: testbench/qdc_properties.sv
// Concurrent checks on the ports of the command decoder.
`timescale 1ns/1ns
module qdc_properties #(
  parameter int NUM_CHAN = qdc_pkg::NUM_CH
)
(
  input wire logic                              mclk,
  input wire logic                              resetn,
  input wire logic                              sclk,
  input wire logic                              frameSelN,
  input wire logic                              serialData,
  input wire qdc_pkg::qdc_chan_s [NUM_CHAN-1:0] activeChan,
  input wire qdc_pkg::qdc_chan_s [NUM_CHAN-1:0] bufferChan,
  input wire qdc_pkg::qdc_ref_e                 refMode,
  input wire logic                              refPowered,
  input wire qdc_pkg::qdc_word_s                cmdWord,
  input wire logic                              cmdStrobe,
  input wire logic                              cmdIgnored
);
  import qdc_pkg::*;
  logic [1:0] ld;
  logic       pdn;
  logic       allDown;
  assign ld  = {cmdWord.updateAllBit, cmdWord.singleLoadBit};
  assign pdn = cmdWord.powerDownEnableBit;
  always_comb begin
    allDown = 1'b1;
    for (int i = 0; i < NUM_CHAN; i++) begin
      allDown = allDown & (activeChan[i].pdMode != PD_NORMAL);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_pulse;
    cmdStrobe ##1 !cmdStrobe;
  endsequence
  sequence s_good;
    cmdStrobe && !cmdIgnored;
  endsequence
  a_strobe_one_cycle:
    assert property (cmdStrobe |-> s_pulse) else $error("strobe longer than one cycle");
  a_idle_hold:
    assert property (!cmdStrobe |-> $stable(activeChan) && $stable(bufferChan) && $stable(refMode))
      else $error("state changed without a frame");
  a_ignored_hold:
    assert property (cmdIgnored |-> cmdStrobe && $stable(activeChan) && $stable(bufferChan))
      else $error("ignored frame changed state");
  a_buffer_only:
    assert property (s_good ##0 ld == LD_BUFFER && !pdn |-> $stable(activeChan)
      && bufferChan[cmdWord.chanSel] == {PD_NORMAL, cmdWord.code}) else $error("buffer write wrong");
  a_single_load:
    assert property (s_good ##0 ld == LD_SINGLE && !pdn |-> activeChan[cmdWord.chanSel] == {PD_NORMAL, cmdWord.code})
      else $error("single load wrong");
  a_update_all:
    assert property (s_good ##0 ld == LD_ALL |-> activeChan == bufferChan) else $error("update all wrong");
  a_broadcast_data:
    assert property (s_good ##0 ld == LD_BROADCAST && !pdn |-> activeChan == {NUM_CHAN{{PD_NORMAL, cmdWord.code}}})
      else $error("broadcast data wrong");
  a_broadcast_down:
    assert property (s_good ##0 ld == LD_BROADCAST && pdn |-> allDown && activeChan[0].pdMode == cmdWord.code[13:12])
      else $error("broadcast power-down wrong");
  a_ref_command:
    assert property (s_good ##0 ld == LD_BUFFER && cmdWord.chanSel == SEL_REF && pdn && cmdWord.code[13:12] == 2'h0
      |-> refMode == qdc_ref_e'(cmdWord.code[11:10])) else $error("reference command wrong");
  a_ref_power:
    assert property (refPowered == (refMode == REF_FORCED_ON || (refMode == REF_AUTO && !allDown)))
      else $error("reference power wrong");
  a_word_hold:
    assert property (!cmdStrobe |-> $stable(cmdWord)) else $error("command word changed without a frame");
endmodule : qdc_properties
bind qdc_command_decoder qdc_properties #(.NUM_CHAN(NUM_CHAN)) chk (.mclk(mclk), .resetn(resetn), .sclk(sclk),
  .frameSelN(frameSelN), .serialData(serialData), .activeChan(activeChan), .bufferChan(bufferChan),
  .refMode(refMode), .refPowered(refPowered), .cmdWord(cmdWord), .cmdStrobe(cmdStrobe), .cmdIgnored(cmdIgnored));

// File: testbench/qdc_host_model.sv
// Host model that clocks command frames into the decoder.
`timescale 1ns/1ns
module qdc_host_model (
  output logic sclk,
  output logic frameSelN,
  output logic serialData
);
  initial begin
    sclk = 1'b1;
    frameSelN = 1'b1;
    serialData = 1'b0;
  end
  task automatic pulse();
    #15 sclk = 1'b0;
    #32 sclk = 1'b1;
    #17;
  endtask : pulse
  task automatic idle(input int n);
    repeat (n) pulse();
  endtask : idle
  task automatic send(input logic [23:0] w);
    frameSelN = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serialData = w[i];
      pulse();
    end
    frameSelN = 1'b1;
    serialData = ~w[0];
    pulse();
  endtask : send
endmodule : qdc_host_model

// File: testbench/qdc_command_decoder_bench.sv
// Self-checking bench for the command decoder.
`timescale 1ns/1ns
module qdc_command_decoder_bench;
  import qdc_pkg::*;
  logic                   mclk, resetn, sclk, frameSelN, serialData, refPowered, cmdStrobe, cmdIgnored, ign;
  qdc_chan_s [NUM_CH-1:0] activeChan, bufferChan;
  qdc_ref_e               refMode;
  qdc_word_s              cmdWord;
  int                     errorCnt, testsRun, cyc;
  qdc_command_decoder uut (.mclk(mclk), .resetn(resetn), .sclk(sclk), .frameSelN(frameSelN),
    .serialData(serialData), .activeChan(activeChan), .bufferChan(bufferChan), .refMode(refMode),
    .refPowered(refPowered), .cmdWord(cmdWord), .cmdStrobe(cmdStrobe), .cmdIgnored(cmdIgnored));
  qdc_host_model host (.sclk(sclk), .frameSelN(frameSelN), .serialData(serialData));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      finishTest();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] mk(input logic [1:0] ld, sel, input logic pd, input logic [13:0] pl);
    return {2'h0, ld, 1'h0, sel, pd, pl, 2'h0};
  endfunction : mk
  task automatic chk(input string nm, input logic [15:0] e, g);
    testsRun++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cmd(input logic [23:0] w);
    int n;
    n = 0;
    fork
      host.send(w);
      do begin
        @(posedge mclk);
        #1;
        n++;
        ign = cmdIgnored;
      end while (cmdStrobe !== 1'b1 && n < 500);
    join
    chk("strobe", 16'h1, {15'h0, n < 500});
    chk("word", w[23:8], cmdWord[23:8]);
  endtask : cmd
  task automatic finishTest();
    if (errorCnt == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finishTest
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    errorCnt = 0;
    testsRun = 0;
    cyc = 0;
    repeat (12) @(posedge mclk);
    host.idle(4);
    @(posedge mclk);
    resetn <= 1'b1;
    host.idle(3);
    chk("refMode", REF_AUTO, refMode);
    chk("refPowered", 16'h1, refPowered);
    cmd(mk(LD_BUFFER, 2'h0, 1'h0, 14'h1234));
    chk("ignNone", 16'h0, ign);
    chk("buffer", 16'h1234, bufferChan[0]);
    chk("active", 16'h0000, activeChan[0]);
    cmd(mk(LD_BUFFER, 2'h1, 1'h0, 14'h2abc));
    cmd(mk(LD_ALL, 2'h3, 1'h0, 14'h3fff));
    chk("allA", 16'h1234, activeChan[0]);
    chk("allB", 16'h2abc, activeChan[1]);
    chk("allD", 16'h3fff, activeChan[3]);
    cmd(mk(LD_SINGLE, 2'h2, 1'h0, 14'h0155));
    chk("singleC", 16'h0155, activeChan[2]);
    cmd(mk(LD_BROADCAST, 2'h1, 1'h0, 14'h0777));
    chk("ignored", 16'h1, ign);
    chk("keptB", 16'h2abc, activeChan[1]);
    for (int m = 1; m < 4; m++) begin
      cmd(mk(LD_SINGLE, 2'h0, 1'h1, {m[1:0], 12'h000}));
      chk("mode", {m[1:0], 14'h1234}, activeChan[0]);
    end
    cmd(mk(LD_BROADCAST, SEL_BROADCAST, 1'h1, {PD_HIZ, 12'h000}));
    chk("hizB", {PD_HIZ, 14'h2abc}, activeChan[1]);
    chk("refAutoOff", 16'h0, refPowered);
    cmd(mk(LD_SINGLE, 2'h0, 1'h0, 14'h0042));
    chk("wakeA", 16'h0042, activeChan[0]);
    chk("refAutoOn", 16'h1, refPowered);
    cmd(mk(LD_BUFFER, SEL_REF, 1'h1, {2'h0, REF_CTL_ON, 10'h000}));
    chk("refOn", REF_FORCED_ON, refMode);
    cmd(mk(LD_BROADCAST, SEL_BROADCAST, 1'h1, {PD_1K, 12'h000}));
    chk("onAllDown", 16'h1, refPowered);
    cmd(mk(LD_BUFFER, SEL_REF, 1'h1, {2'h0, REF_CTL_OFF, 10'h000}));
    cmd(mk(LD_BROADCAST, SEL_BROADCAST, 1'h0, 14'h2222));
    for (int i = 0; i < NUM_CH; i++) begin
      chk("bcast", 16'h2222, activeChan[i]);
    end
    chk("refOff", 16'h0, refPowered);
    cmd(mk(LD_BUFFER, SEL_REF, 1'h1, {2'h0, REF_CTL_AUTO, 10'h000}));
    chk("refAuto", REF_AUTO, refMode);
    chk("refAutoPow", 16'h1, refPowered);
    cmd(mk(LD_BUFFER, 2'h1, 1'h1, {PD_1K, 12'h000}));
    chk("pdBufB", {PD_1K, 14'h2222}, bufferChan[1]);
    chk("pdActB", {PD_NORMAL, 14'h2222}, activeChan[1]);
    cmd(mk(LD_ALL, 2'h3, 1'h1, {PD_100K, 12'h000}));
    chk("pdAllB", {PD_1K, 14'h2222}, activeChan[1]);
    chk("pdAllD", {PD_100K, 14'h2222}, activeChan[3]);
    chk("pdAllA", {PD_NORMAL, 14'h2222}, activeChan[0]);
    chk("refSomeUp", 16'h1, refPowered);
    finishTest();
  end
endmodule : qdc_command_decoder_bench
